// File: rtl/adcrts_pkg.sv
// Package for the converter round trigger sequencer
package adcrts_pkg;

	localparam int unsigned ADDR_W = 12;

	// Register byte offsets
	localparam logic [11:0] OFS_CONVERTER_CONFIG = 12'h000;
	localparam logic [11:0] OFS_TRIGGER_CONFIG   = 12'h004;
	localparam logic [11:0] OFS_ROUND_COUNT0     = 12'h008;
	localparam logic [11:0] OFS_ROUND_COUNT1     = 12'h00C;
	localparam logic [11:0] OFS_SOFTWARE_TRIGGER = 12'h010;
	localparam logic [11:0] OFS_STATUS           = 12'h014;
	localparam logic [11:0] OFS_RESULT_BASE      = 12'h040;

	// Converter configuration fields
	localparam int unsigned CFG_SEQ_RESET_BIT = 2;
	localparam int unsigned CFG_MODE_LSB      = 4;
	localparam int unsigned CFG_EVCNT_LSB     = 8;
	localparam logic [31:0] CFG_RESET         = 32'h0000_0000;

	// Trigger configuration fields: enable per event in bits 3:0
	localparam int unsigned TRG_EN_LSB = 0;
	localparam logic [31:0] TRG_RESET  = 32'h0000_0000;

	// Round count fields
	localparam int unsigned CNT_LO_LSB  = 0;
	localparam int unsigned CNT_HI_LSB  = 8;
	localparam int unsigned CNT_W       = 5;
	localparam logic [31:0] CNT_RESET   = 32'h0000_0000;
	localparam logic [4:0]  CNT_MAX     = 5'h14;

	localparam logic [15:0] SW_TRIGGER_KEY = 16'h5AA5;

	// Status fields
	localparam int unsigned ST_DONE_BIT  = 0;
	localparam int unsigned ST_ERR_BIT   = 1;
	localparam int unsigned ST_BUSY_BIT  = 2;
	localparam int unsigned ST_STATE_LSB = 4;
	localparam int unsigned ST_SLOT_LSB  = 12;

	typedef enum logic [1:0] {
		ADCRTS_MODE_ONE  = 2'h0,
		ADCRTS_MODE_TWO  = 2'h1,
		ADCRTS_MODE_FOUR = 2'h2
	} adcrts_mode_e;

	typedef enum logic [7:0] {
		ST_IDLE0 = 8'h01,
		ST_SAMP0 = 8'h02,
		ST_IDLE1 = 8'h04,
		ST_SAMP1 = 8'h08,
		ST_IDLE2 = 8'h10,
		ST_SAMP2 = 8'h20,
		ST_IDLE3 = 8'h40,
		ST_SAMP3 = 8'h80
	} adcrts_state_e;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} adcrts_conv_s;

endpackage : adcrts_pkg

// File: rtl/adcrts_sequencer.sv
// Converter round trigger sequencer with APB register slave
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Round count field sets conversions, 1 to 20
// - Results fill consecutive slots across rounds
// - Single round: software or counted hardware events
// - Single round ends idle with done flag
// - Two rounds: event0 then event1, second count
// - Four rounds: events 0..3, four count fields
// - Software trigger only when idle, else error
// - Key 0x5AA5 makes one software trigger
// - Two rounds: done flag after each round
// - Four rounds: done flag after each round
// - Reset bit forces sequencer back to idle
// - Zero trigger config disables hardware triggers
// - Multi-round modes start on single event
module adcrts_sequencer #(
	parameter int unsigned SLOTS = 20
) (
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST_N,
	input  wire logic                 CLK_EN,
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [11:0]          PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	input  wire logic [3:0]           TIMING_TRIGGER_EVENT,
	output logic                      CONV_START,
	output logic      [4:0]           CONV_SLOT,
	input  wire adcrts_pkg::adcrts_conv_s CONV_RESULT,
	output logic                      DONE_PULSE,
	output logic                      ERROR_PULSE
);

	logic [31:0] cfg_q, trg_q, cnt0_q, cnt1_q;
	logic [15:0] result_q [SLOTS];
	logic [3:0]  ev_s1_q, ev_s2_q, ev_prev_q;
	logic [3:0]  ev_rise;
	logic [7:0]  ev_count_q;
	adcrts_pkg::adcrts_state_e state_q;
	logic [4:0]  slot_q, done_in_round_q;
	logic        busy_conv_q, done_flag_q, err_flag_q;
	logic        wr_en, sw_key, seq_reset;
	logic        sw_trig, hw_trig, start_round, round_end;
	logic [4:0]  round_len;
	adcrts_pkg::adcrts_mode_e mode;
	logic        sampling;

	function automatic logic [4:0] cnt_field(input logic [31:0] r, input int unsigned lsb);
		cnt_field = r[lsb +: adcrts_pkg::CNT_W];
	endfunction : cnt_field

	assign wr_en   = PSEL && PENABLE && PWRITE && CLK_EN;
	assign PREADY  = 1'b1;
	assign mode    = adcrts_pkg::adcrts_mode_e'(cfg_q[adcrts_pkg::CFG_MODE_LSB +: 2]);
	assign sampling = (state_q == adcrts_pkg::ST_SAMP0) || (state_q == adcrts_pkg::ST_SAMP1)
		|| (state_q == adcrts_pkg::ST_SAMP2) || (state_q == adcrts_pkg::ST_SAMP3);

	assign sw_key = wr_en && (PADDR == adcrts_pkg::OFS_SOFTWARE_TRIGGER)
		&& (PWDATA[15:0] == adcrts_pkg::SW_TRIGGER_KEY);
	assign seq_reset = wr_en && (PADDR == adcrts_pkg::OFS_CONVERTER_CONFIG)
		&& PWDATA[adcrts_pkg::CFG_SEQ_RESET_BIT];
	assign sw_trig = sw_key && !sampling;

	// Event pins are outside this clock domain
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ev_s1_q   <= 4'h0;
			ev_s2_q   <= 4'h0;
			ev_prev_q <= 4'h0;
		end
		else if (CLK_EN)
		begin
			ev_s1_q   <= TIMING_TRIGGER_EVENT;
			ev_s2_q   <= ev_s1_q;
			ev_prev_q <= ev_s2_q;
		end
	end
	assign ev_rise = ev_s2_q & ~ev_prev_q & trg_q[adcrts_pkg::TRG_EN_LSB +: 4];

	// counted hardware events in single round
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			ev_count_q <= 8'h00;
		else if (CLK_EN)
		begin
			if (seq_reset || (start_round && state_q == adcrts_pkg::ST_IDLE0))
				ev_count_q <= 8'h00;
			else if (|ev_rise && mode == adcrts_pkg::ADCRTS_MODE_ONE)
				ev_count_q <= ev_count_q + 8'h01;
		end
	end

	always_comb
	begin
		hw_trig = 1'b0;
		round_len = cnt_field(cnt0_q, adcrts_pkg::CNT_LO_LSB);
		unique case (state_q)
			adcrts_pkg::ST_IDLE0:
			begin
				if (mode == adcrts_pkg::ADCRTS_MODE_ONE)
					hw_trig = |ev_rise && ((ev_count_q + 8'h01)
						>= cfg_q[adcrts_pkg::CFG_EVCNT_LSB +: 8]);
				else
					hw_trig = ev_rise[0];
			end
			adcrts_pkg::ST_IDLE1: hw_trig = ev_rise[1];
			adcrts_pkg::ST_IDLE2: hw_trig = ev_rise[2];
			adcrts_pkg::ST_IDLE3: hw_trig = ev_rise[3];
			adcrts_pkg::ST_SAMP1: round_len = cnt_field(cnt0_q, adcrts_pkg::CNT_HI_LSB);
			adcrts_pkg::ST_SAMP2: round_len = cnt_field(cnt1_q, adcrts_pkg::CNT_LO_LSB);
			adcrts_pkg::ST_SAMP3: round_len = cnt_field(cnt1_q, adcrts_pkg::CNT_HI_LSB);
			default: hw_trig = 1'b0;
		endcase
		if (round_len > adcrts_pkg::CNT_MAX)
			round_len = adcrts_pkg::CNT_MAX;
	end
	assign start_round = !sampling && (hw_trig || sw_trig);
	assign round_end = sampling && CONV_RESULT.valid
		&& ((done_in_round_q + 5'h01) >= round_len);

	// Sequencer state
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			state_q <= adcrts_pkg::ST_IDLE0;
		else if (CLK_EN)
		begin
			if (seq_reset)
				state_q <= adcrts_pkg::ST_IDLE0;
			else if (start_round)
				state_q <= adcrts_pkg::adcrts_state_e'({state_q[6:0], 1'b0});
			else if (round_end)
			begin
				unique case (state_q)
					adcrts_pkg::ST_SAMP0:
						state_q <= (mode == adcrts_pkg::ADCRTS_MODE_ONE)
							? adcrts_pkg::ST_IDLE0 : adcrts_pkg::ST_IDLE1;
					adcrts_pkg::ST_SAMP1:
						state_q <= (mode == adcrts_pkg::ADCRTS_MODE_TWO)
							? adcrts_pkg::ST_IDLE0 : adcrts_pkg::ST_IDLE2;
					adcrts_pkg::ST_SAMP2: state_q <= adcrts_pkg::ST_IDLE3;
					default: state_q <= adcrts_pkg::ST_IDLE0;
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			slot_q          <= 5'h00;
			done_in_round_q <= 5'h00;
			busy_conv_q     <= 1'b0;
		end
		else if (CLK_EN)
		begin
			if (seq_reset)
			begin
				slot_q          <= 5'h00;
				done_in_round_q <= 5'h00;
				busy_conv_q     <= 1'b0;
			end
			else if (start_round)
			begin
				done_in_round_q <= 5'h00;
				busy_conv_q     <= 1'b0;
			end
			else if (sampling && CONV_RESULT.valid)
			begin
				busy_conv_q     <= 1'b0;
				done_in_round_q <= done_in_round_q + 5'h01;
				if (round_end && (state_q == adcrts_pkg::ST_SAMP3
					|| (state_q == adcrts_pkg::ST_SAMP1 && mode == adcrts_pkg::ADCRTS_MODE_TWO)
					|| (state_q == adcrts_pkg::ST_SAMP0 && mode == adcrts_pkg::ADCRTS_MODE_ONE)))
					slot_q <= 5'h00;
				else if (slot_q < 5'(SLOTS - 1))
					slot_q <= slot_q + 5'h01;
			end
			else if (CONV_START)
				busy_conv_q <= 1'b1;
		end
	end
	assign CONV_START = sampling && !busy_conv_q && !CONV_RESULT.valid;
	assign CONV_SLOT  = slot_q;

	always_ff @(posedge SYS_CLK)
	begin
		if (CLK_EN && sampling && CONV_RESULT.valid)
			result_q[slot_q] <= CONV_RESULT.data;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			done_flag_q <= 1'b0;
			err_flag_q  <= 1'b0;
			DONE_PULSE  <= 1'b0;
			ERROR_PULSE <= 1'b0;
		end
		else if (CLK_EN)
		begin
			DONE_PULSE  <= round_end;
			ERROR_PULSE <= sw_key && sampling;
			// Set wins over write-one clear
			if (round_end)
				done_flag_q <= 1'b1;
			else if (wr_en && PADDR == adcrts_pkg::OFS_STATUS && PWDATA[adcrts_pkg::ST_DONE_BIT])
				done_flag_q <= 1'b0;
			if (sw_key && sampling)
				err_flag_q <= 1'b1;
			else if (wr_en && PADDR == adcrts_pkg::OFS_STATUS && PWDATA[adcrts_pkg::ST_ERR_BIT])
				err_flag_q <= 1'b0;
		end
	end

	// Config registers; reset bit self-clears
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cfg_q  <= adcrts_pkg::CFG_RESET;
			trg_q  <= adcrts_pkg::TRG_RESET;
			cnt0_q <= adcrts_pkg::CNT_RESET;
			cnt1_q <= adcrts_pkg::CNT_RESET;
		end
		else if (wr_en)
		begin
			unique case (PADDR)
				adcrts_pkg::OFS_CONVERTER_CONFIG:
					cfg_q <= PWDATA & ~(32'h1 << adcrts_pkg::CFG_SEQ_RESET_BIT);
				adcrts_pkg::OFS_TRIGGER_CONFIG: trg_q <= PWDATA & 32'h0000_000F;
				adcrts_pkg::OFS_ROUND_COUNT0:   cnt0_q <= PWDATA & 32'h0000_1F1F;
				adcrts_pkg::OFS_ROUND_COUNT1:   cnt1_q <= PWDATA & 32'h0000_1F1F;
				default: ;
			endcase
		end
	end

	// Read data from flip-flops
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else if (CLK_EN)
		begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			if (PSEL && !PENABLE && !PWRITE)
			begin
				unique case (PADDR)
					adcrts_pkg::OFS_CONVERTER_CONFIG: PRDATA <= cfg_q;
					adcrts_pkg::OFS_TRIGGER_CONFIG:   PRDATA <= trg_q;
					adcrts_pkg::OFS_ROUND_COUNT0:     PRDATA <= cnt0_q;
					adcrts_pkg::OFS_ROUND_COUNT1:     PRDATA <= cnt1_q;
					adcrts_pkg::OFS_SOFTWARE_TRIGGER: PRDATA <= 32'h0000_0000;
					adcrts_pkg::OFS_STATUS:
						PRDATA <= (32'(state_q) << adcrts_pkg::ST_STATE_LSB)
							| (32'(slot_q) << adcrts_pkg::ST_SLOT_LSB)
							| (32'(sampling) << adcrts_pkg::ST_BUSY_BIT)
							| (32'(err_flag_q) << adcrts_pkg::ST_ERR_BIT)
							| (32'(done_flag_q) << adcrts_pkg::ST_DONE_BIT);
					default:
						if (PADDR >= adcrts_pkg::OFS_RESULT_BASE
							&& PADDR < adcrts_pkg::OFS_RESULT_BASE + 12'(SLOTS * 4)
							&& PADDR[1:0] == 2'h0)
							PRDATA <= {16'h0, result_q[5'((PADDR - adcrts_pkg::OFS_RESULT_BASE) >> 2)]};
						else
							PSLVERR <= 1'b1;
				endcase
			end
		end
	end

endmodule : adcrts_sequencer

`default_nettype wire

// File: bench/adcrts_sequencer_sva.sv
// Port checker for the round trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module adcrts_sequencer_sva #(
	parameter int unsigned SLOTS = 20
) (
	input wire logic                     SYS_CLK,
	input wire logic                     RST_N,
	input wire logic                     CLK_EN,
	input wire logic                     PSEL,
	input wire logic                     PENABLE,
	input wire logic                     PWRITE,
	input wire logic [11:0]              PADDR,
	input wire logic [31:0]              PWDATA,
	input wire logic                     CONV_START,
	input wire logic [4:0]               CONV_SLOT,
	input wire adcrts_pkg::adcrts_conv_s CONV_RESULT,
	input wire logic                     DONE_PULSE,
	input wire logic                     ERROR_PULSE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire acc = CLK_EN && PSEL && PENABLE && PWRITE;
	wire key = PADDR == adcrts_pkg::OFS_SOFTWARE_TRIGGER && PWDATA[15:0] == 16'h5AA5;
	sequence s_req_once; CONV_START ##1 !CONV_START; endsequence
	sequence s_quiet; !CONV_START [*2]; endsequence
	property p_done_width; DONE_PULSE |=> !DONE_PULSE; endproperty
	a_done_width: assert property (p_done_width) else $error("done too long");
	property p_err_width; ERROR_PULSE |=> !ERROR_PULSE; endproperty
	a_err_width: assert property (p_err_width) else $error("error too long");
	property p_err_cause; ERROR_PULSE |-> $past(acc && key); endproperty
	a_err_cause: assert property (p_err_cause) else $error("error without key");
	property p_done_cause; DONE_PULSE |-> $past(CONV_RESULT.valid) || $past(CONV_RESULT.valid, 2); endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without result");
	property p_req_once; CONV_START && CLK_EN |-> s_req_once; endproperty
	a_req_once: assert property (p_req_once) else $error("request repeated");
	property p_slot_max; CONV_SLOT <= 5'(SLOTS - 1); endproperty
	a_slot_max: assert property (p_slot_max) else $error("slot out of range");
	property p_slot_step;
		CONV_RESULT.valid && CLK_EN |=> CONV_SLOT == $past(CONV_SLOT) + 5'h01 || CONV_SLOT == 5'h00
			|| CONV_SLOT == 5'(SLOTS - 1);
	endproperty
	a_slot_step: assert property (p_slot_step) else $error("slot not advanced");
	property p_seq_reset; acc && PADDR == adcrts_pkg::OFS_CONVERTER_CONFIG && PWDATA[2] |=> s_quiet; endproperty
	a_seq_reset: assert property (p_seq_reset) else $error("request after reset");
endmodule : adcrts_sequencer_sva
bind adcrts_sequencer adcrts_sequencer_sva #(.SLOTS(SLOTS)) u_sva (.SYS_CLK, .RST_N, .CLK_EN, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PWDATA, .CONV_START, .CONV_SLOT, .CONV_RESULT, .DONE_PULSE,
	.ERROR_PULSE);
`default_nettype wire

// File: bench/adcrts_conv_model.sv
// Behavioural converter answering conversion requests
`timescale 1ns/1ns
`default_nettype none
module adcrts_conv_model (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    start,
	input  wire logic [4:0]              slot,
	input  wire logic [3:0]              lat,
	input  wire logic [7:0]              tag,
	output var adcrts_pkg::adcrts_conv_s res
);
	logic       busy;
	logic [3:0] cnt;
	logic [4:0] sl;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			busy <= 1'b0;
		else
			busy <= busy ? cnt != 4'h0 : start;
	always_ff @(posedge clk)
		if (!busy)
		begin
			cnt <= lat;
			sl  <= slot;
		end
		else
			cnt <= cnt - 4'h1;
	// Data toggles outside the result pulse
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			res <= '0;
		else if (busy && cnt == 4'h0)
			res <= {1'b1, tag, 3'h0, sl};
		else
			res <= {1'b0, ~res.data};
endmodule : adcrts_conv_model
`default_nettype wire

// File: bench/adcrts_sequencer_tb.sv
// Bench for the converter round trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module adcrts_sequencer_tb;
	logic                     clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0]              paddr = 12'h000;
	logic [31:0]              pwdata = 32'h0, prdata, rd;
	logic [7:0]               tag = 8'h00;
	logic [3:0]               ev = 4'h0, lat = 4'h2;
	logic [4:0]               slot;
	logic                     pready, slverr, serr, start, done, err;
	adcrts_pkg::adcrts_conv_s res;
	int                       n_mismatch = 0, samples_checked = 0, n_conv = 0, n_done = 0;
	always #2 clk = ~clk;
	always @(posedge clk) n_conv += int'(res.valid === 1'b1);
	always @(posedge clk) n_done += int'(done === 1'b1);
	adcrts_sequencer u_dut (
		.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(slverr), .TIMING_TRIGGER_EVENT(ev), .CONV_START(start), .CONV_SLOT(slot),
		.CONV_RESULT(res), .DONE_PULSE(done), .ERROR_PULSE(err)
	);
	adcrts_conv_model u_conv (
		.clk(clk), .rst_n(rst_n), .start(start), .slot(slot), .lat(lat), .tag(tag), .res(res)
	);
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd   = prdata;
		serr = slverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	task automatic sw_trig();
		apb(1'b1, adcrts_pkg::OFS_SOFTWARE_TRIGGER, 32'h5AA5);
	endtask : sw_trig
	task automatic wait_done(input int k);
		for (int i = 0; i < 3000 && n_done < k; i++)
			@(posedge clk);
		chk(n_done, k);
	endtask : wait_done
	task automatic wait_start();
		for (int i = 0; i < 200 && start !== 1'b1; i++)
			@(posedge clk);
		chk(32'(start), 32'h1);
	endtask : wait_start
	task automatic pulse_event(input int k);
		@(posedge clk);
		ev <= 4'h1 << k;
		repeat (4) @(posedge clk);
		ev <= 4'h0;
	endtask : pulse_event
	task automatic chk_results(input int last);
		for (int n = 0; n <= last; n++)
		begin
			apb(1'b0, adcrts_pkg::OFS_RESULT_BASE + 12'(4 * n), 32'h0);
			chk({16'h0, rd[15:0]}, {16'h0, tag, 3'h0, 5'(n)});
		end
	endtask : chk_results
	task automatic t_single();
		apb(1'b1, adcrts_pkg::OFS_CONVERTER_CONFIG, 32'h0);
		for (int c = 1; c <= 20; c += 19)
		begin
			n_conv = 0;
			n_done = 0;
			tag    <= 8'(c);
			apb(1'b1, adcrts_pkg::OFS_ROUND_COUNT0, 32'(c));
			sw_trig();
			wait_done(1);
			chk(n_conv, c);
		end
		chk_results(19);
		apb(1'b0, adcrts_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h1);
	endtask : t_single
	task automatic t_two();
		n_conv = 0;
		n_done = 0;
		lat    <= 4'h9;
		tag    <= 8'h22;
		apb(1'b1, adcrts_pkg::OFS_CONVERTER_CONFIG, 32'h10);
		apb(1'b1, adcrts_pkg::OFS_ROUND_COUNT0, 32'h0302);
		apb(1'b1, adcrts_pkg::OFS_TRIGGER_CONFIG, 32'hF);
		pulse_event(0);
		wait_start();
		sw_trig();
		@(posedge clk);
		chk(32'(err), 32'h1);
		wait_done(1);
		chk(n_conv, 2);
		pulse_event(1);
		wait_done(2);
		chk(n_conv, 5);
		chk_results(4);
		apb(1'b1, adcrts_pkg::OFS_TRIGGER_CONFIG, 32'h0);
		pulse_event(0);
		repeat (20) @(posedge clk);
		chk(n_conv, 5);
	endtask : t_two
	task automatic t_four();
		n_conv = 0;
		n_done = 0;
		lat    <= 4'h0;
		tag    <= 8'h44;
		apb(1'b1, adcrts_pkg::OFS_CONVERTER_CONFIG, 32'h20);
		apb(1'b1, adcrts_pkg::OFS_ROUND_COUNT0, 32'h0201);
		apb(1'b1, adcrts_pkg::OFS_ROUND_COUNT1, 32'h0403);
		for (int k = 1; k <= 4; k++)
		begin
			if (k == 3)
				apb(1'b1, adcrts_pkg::OFS_TRIGGER_CONFIG, 32'hC);
			if (k < 3)
				sw_trig();
			else
				pulse_event(k - 1);
			wait_done(k);
			chk(n_conv, k * (k + 1) / 2);
		end
		chk_results(9);
		apb(1'b1, adcrts_pkg::OFS_TRIGGER_CONFIG, 32'h0);
	endtask : t_four
	task automatic t_reset();
		lat <= 4'h9;
		apb(1'b1, adcrts_pkg::OFS_CONVERTER_CONFIG, 32'h0);
		apb(1'b1, adcrts_pkg::OFS_ROUND_COUNT0, 32'h5);
		n_done = 0;
		sw_trig();
		wait_start();
		apb(1'b1, adcrts_pkg::OFS_CONVERTER_CONFIG, 32'h4);
		repeat (80) @(posedge clk);
		chk(n_done, 0);
		apb(1'b0, adcrts_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h0);
	endtask : t_reset
	task automatic t_count();
		lat    <= 4'h0;
		n_conv = 0;
		n_done = 0;
		apb(1'b1, adcrts_pkg::OFS_CONVERTER_CONFIG, 32'h0300);
		apb(1'b1, adcrts_pkg::OFS_ROUND_COUNT0, 32'h2);
		apb(1'b1, adcrts_pkg::OFS_TRIGGER_CONFIG, 32'h4);
		pulse_event(2);
		pulse_event(2);
		repeat (10) @(posedge clk);
		chk(n_conv, 0);
		pulse_event(2);
		wait_done(1);
		chk(n_conv, 2);
		chk_results(1);
		apb(1'b1, adcrts_pkg::OFS_TRIGGER_CONFIG, 32'h0);
	endtask : t_count
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, adcrts_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h10);
		apb(1'b0, 12'h3FC, 32'h0);
		chk(32'(serr), 32'h1);
		t_single();
		t_two();
		t_four();
		t_reset();
		t_count();
		wrap_up();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
endmodule : adcrts_sequencer_tb
`default_nettype wire
